// >>> hw/adcc_top.sv
/*
 holds the converter control block: AXI4-Lite registers, conversion clock divider, channel select,
 power, halt handling, sticky events and the interrupt output.
 assumes an external analog mux, sample/hold, trial DAC and comparator driven from these ports.
*/
`timescale 1ns/100ps
`include "adcc_cfg.svh"

module adcc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic cmp_in,
  output logic [3:0] input_select,
  output logic input_valid,
  output logic converter_power,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic irq
);
  adcc_pkg::adcc_csr_t csr_r;
  adcc_pkg::adcc_result_t sar_res;
  logic [9:0] result_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic [11:0] stab_cnt_r;
  logic [1:0] div_cnt_r;
  logic [1:0] div_end;
  logic tick;
  logic run;
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic do_write;
  logic do_read;
  logic csr_wr;
  logic sel_change;
  logic high_rd;
  logic done_clr;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // comparator is analog, so it is a foreign-domain level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cmp_meta_r <= cmp_in;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign do_read = s_axi_arvalid && !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_r)
      `ADCC_ADDR_CSR, `ADCC_ADDR_IRQ_STATUS, `ADCC_ADDR_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `ADCC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign csr_wr = do_write && awaddr_r == `ADCC_ADDR_CSR && wstrb_r[0];
  assign sel_change = csr_wr && wdata_r[3:0] != csr_r.input_select;
  assign high_rd = do_read && s_axi_araddr == `ADCC_ADDR_RES_HIGH;
  assign done_clr = high_rd || csr_wr;

  // reserved bit is never stored, so it reads back zero whatever software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_r <= `ADCC_CSR_RESET;
    end else begin
      if (csr_wr) begin
        csr_r.speed <= wdata_r[6];
        csr_r.on <= wdata_r[5];
        csr_r.input_select <= wdata_r[3:0];
      end
      csr_r.rsvd <= 1'b0;
      // a completion in the clearing cycle wins
      if (sar_res.done) csr_r.done <= 1'b1;
      else if (done_clr || sel_change) csr_r.done <= 1'b0;
    end
  end

  // new result visible together with done; no shadow copy, so a late reader may mix two results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 10'h000;
    end else if (sar_res.done) begin
      result_r <= sar_res.value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stab_cnt_r <= 12'h000;
    end else if (halt_mode) begin
      stab_cnt_r <= `ADCC_STAB_CYC;
    end else if (stab_cnt_r != 12'h000) begin
      stab_cnt_r <= stab_cnt_r - 12'h001;
    end
  end

  // wait_mode is deliberately unused by the converter path
  assign run = csr_r.on && !halt_mode;
  assign converter_power = run;
  assign input_select = csr_r.input_select;
  assign input_valid = {1'b0, csr_r.input_select} < `ADCC_NUM_INPUTS;
  assign div_end = csr_r.speed ? `ADCC_DIV_FAST : `ADCC_DIV_SLOW;
  assign tick = run && div_cnt_r == div_end;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 2'h0;
    end else if (!run || tick) begin
      div_cnt_r <= 2'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end

  adcc_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .run(run),
    .restart(sel_change),
    .cmp_sync(cmp_sync_r),
    .dac_code(dac_code),
    .sample_hold(sample_hold),
    .result(sar_res)
  );

  // overrun: a result lands while the previous one was still flagged unread
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= `ADCC_IRQ_RESET;
      irq_mask_r <= `ADCC_IRQ_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `ADCC_IRQ_DONE && sar_res.done) || (i == `ADCC_IRQ_OVERRUN && sar_res.done && csr_r.done)) begin
          irq_status_r[i] <= 1'b1;
        end else if (do_write && awaddr_r == `ADCC_ADDR_IRQ_STATUS && wstrb_r[0] && wdata_r[i]) begin
          irq_status_r[i] <= 1'b0;
        end
      end
      if (do_write && awaddr_r == `ADCC_ADDR_IRQ_MASK && wstrb_r[0]) irq_mask_r <= wdata_r[1:0];
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ADCC_ADDR_CSR: rd_word[7:0] = csr_r;
      `ADCC_ADDR_RES_HIGH: rd_word[7:0] = result_r[9:2];
      `ADCC_ADDR_RES_LOW: rd_word[7:0] = {6'h00, result_r[1:0]};
      `ADCC_ADDR_IRQ_STATUS: rd_word[1:0] = irq_status_r;
      `ADCC_ADDR_IRQ_MASK: rd_word[1:0] = irq_mask_r;
      `ADCC_ADDR_AUX_STATUS: rd_word[2:0] = {wait_mode, input_valid, stab_cnt_r != 12'h000};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= `ADCC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      rdata_r <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  sequence s_off_write;
    csr_wr && !wdata_r[5];
  endsequence

  property p_off_stops;
    @(posedge aclk) disable iff (!aresetn)
      s_off_write ##1 !csr_wr [*3] |-> !converter_power && !sar_res.done && !tick;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("converter still running after off");

  property p_wait_free;
    @(posedge aclk) disable iff (!aresetn)
      (csr_r.on && !halt_mode && wait_mode) |-> converter_power;
  endproperty
  a_wait_free: assert property (p_wait_free) else $error("wait mode stopped converter");

  property p_halt_off;
    @(posedge aclk) disable iff (!aresetn)
      halt_mode |-> !converter_power ##1 stab_cnt_r == `ADCC_STAB_CYC;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt did not disable converter");

  property p_high_read_clears;
    @(posedge aclk) disable iff (!aresetn)
      (high_rd && !sar_res.done) |=> !csr_r.done;
  endproperty
  a_high_read_clears: assert property (p_high_read_clears) else $error("high read left done set");

  property p_div_spacing;
    @(posedge aclk) disable iff (!aresetn)
      (tick && !csr_r.speed) ##1 (run && !csr_r.speed) [*4] |-> tick && !$past(tick);
  endproperty
  a_div_spacing: assert property (p_div_spacing) else $error("slow divider not four cycles");

  property p_on_starts;
    @(posedge aclk) disable iff (!aresetn)
      (csr_wr && wdata_r[5] && !halt_mode && (!run || sel_change)) ##1 !halt_mode |-> converter_power ##1 sample_hold;
  endproperty
  a_on_starts: assert property (p_on_starts) else $error("converter did not start");

  property p_result_bytes;
    @(posedge aclk) disable iff (!aresetn)
      (do_read && s_axi_araddr == `ADCC_ADDR_RES_LOW) |=>
        s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[1:0] == $past(result_r[1:0]);
  endproperty
  a_result_bytes: assert property (p_result_bytes) else $error("low result layout wrong");

  property p_reset_csr;
    @(posedge aclk) !aresetn |=> csr_r == `ADCC_CSR_RESET && !converter_power;
  endproperty
  a_reset_csr: assert property (p_reset_csr) else $error("reset left csr nonzero");

  property p_sel_abort;
    @(posedge aclk) disable iff (!aresetn)
      (sel_change && !sar_res.done) |=> !csr_r.done && csr_r.input_select == $past(wdata_r[3:0]);
  endproperty
  a_sel_abort: assert property (p_sel_abort) else $error("select change kept done");

  property p_done_with_result;
    @(posedge aclk) disable iff (!aresetn)
      sar_res.done |=> csr_r.done && result_r == $past(sar_res.value) && irq_status_r[0];
  endproperty
  a_done_with_result: assert property (p_done_with_result) else $error("result and done not together");
endmodule

// >>> hw/adcc_cfg.svh
/*
 holds the offsets, field positions, reset values and timing counts of the converter control block.
 assumes a 100 MHz aclk and a 12-bit AXI4-Lite byte address.
*/
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_IDX_CSR 10'h070
`define ADCC_IDX_RES_HIGH 10'h071
`define ADCC_IDX_RES_LOW 10'h072
`define ADCC_IDX_IRQ_STATUS 10'h073
`define ADCC_IDX_IRQ_MASK 10'h074
`define ADCC_IDX_AUX_STATUS 10'h075

`define ADCC_ADDR_CSR {`ADCC_IDX_CSR, 2'b00}
`define ADCC_ADDR_RES_HIGH {`ADCC_IDX_RES_HIGH, 2'b00}
`define ADCC_ADDR_RES_LOW {`ADCC_IDX_RES_LOW, 2'b00}
`define ADCC_ADDR_IRQ_STATUS {`ADCC_IDX_IRQ_STATUS, 2'b00}
`define ADCC_ADDR_IRQ_MASK {`ADCC_IDX_IRQ_MASK, 2'b00}
`define ADCC_ADDR_AUX_STATUS {`ADCC_IDX_AUX_STATUS, 2'b00}

`define ADCC_CSR_RESET 8'h00
`define ADCC_CSR_WR_MASK 8'h6f
`define ADCC_IRQ_RESET 2'h0
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_OVERRUN 1

`define ADCC_NUM_INPUTS 5'h10
`define ADCC_DIV_SLOW 2'h3
`define ADCC_DIV_FAST 2'h1
`define ADCC_SAR_MSB 4'h9
`define ADCC_SAR_FIRST 10'h200

`define ADCC_CLK_MHZ 100
`define ADCC_STAB_NS 1000
`define ADCC_STAB_CYC 12'((`ADCC_STAB_NS * `ADCC_CLK_MHZ + 999) / 1000)

`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

// >>> hw/adcc_pkg.sv
/*
 holds the types of the converter control block.
 assumes adcc_cfg.svh for the numeric constants.
*/
package adcc_pkg;
  typedef struct packed {
    logic done;
    logic speed;
    logic on;
    logic rsvd;
    logic [3:0] input_select;
  } adcc_csr_t;

  typedef struct packed {
    logic done;
    logic [9:0] value;
  } adcc_result_t;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_SAMPLE,
    ADCC_CONV
  } adcc_sar_state_t;
endpackage

// >>> hw/adcc_sar.sv
/*
 holds the successive-approximation sequencer: sample, then ten trial bits, then repeat.
 assumes a synchronised comparator level, high while the input is at or above dac_code.
*/
`timescale 1ns/100ps
`include "adcc_cfg.svh"

module adcc_sar (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic cmp_sync,
  output logic [9:0] dac_code,
  output logic sample_hold,
  output adcc_pkg::adcc_result_t result
);
  adcc_pkg::adcc_sar_state_t state_r;
  logic [3:0] bit_r;
  logic phase_r;
  logic [9:0] trial_r;
  logic [9:0] onehot;
  logic [9:0] decided;
  logic last_step;

  assign onehot = 10'h001 << bit_r;
  // a low comparator drops the trial bit; all-high input ends at full scale
  assign decided = cmp_sync ? trial_r : (trial_r & ~onehot);
  assign last_step = (state_r == adcc_pkg::ADCC_CONV) && tick && phase_r && (bit_r == 4'h0);
  assign dac_code = trial_r;
  assign sample_hold = (state_r == adcc_pkg::ADCC_SAMPLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= adcc_pkg::ADCC_IDLE;
    end else if (!run || restart) begin
      state_r <= adcc_pkg::ADCC_IDLE;
    end else begin
      case (state_r)
        adcc_pkg::ADCC_IDLE: state_r <= adcc_pkg::ADCC_SAMPLE;
        adcc_pkg::ADCC_SAMPLE: if (tick) state_r <= adcc_pkg::ADCC_CONV;
        adcc_pkg::ADCC_CONV: if (last_step) state_r <= adcc_pkg::ADCC_SAMPLE;
        default: state_r <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  // two ticks per bit so the two-stage comparator sync sees the new trial
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trial_r <= 10'h000;
      bit_r <= 4'h0;
      phase_r <= 1'b0;
    end else if (state_r == adcc_pkg::ADCC_SAMPLE && tick) begin
      trial_r <= `ADCC_SAR_FIRST;
      bit_r <= `ADCC_SAR_MSB;
      phase_r <= 1'b0;
    end else if (state_r == adcc_pkg::ADCC_CONV && tick) begin
      phase_r <= ~phase_r;
      if (phase_r && bit_r != 4'h0) begin
        trial_r <= decided | (onehot >> 1);
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
    end else begin
      result.done <= last_step && run && !restart;
      if (last_step && run && !restart) result.value <= decided;
    end
  end

  property p_abort_quiet;
    @(posedge aclk) disable iff (!aresetn)
      restart |=> (state_r == adcc_pkg::ADCC_IDLE) && !result.done;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("restart did not abort conversion");

  property p_repeat;
    @(posedge aclk) disable iff (!aresetn)
      (last_step && run && !restart) |=> state_r == adcc_pkg::ADCC_SAMPLE;
  endproperty
  a_repeat: assert property (p_repeat) else $error("no new conversion after done");

  property p_full_scale;
    @(posedge aclk) disable iff (!aresetn)
      (last_step && run && !restart && trial_r == 10'h3ff && cmp_sync) |=> result.value == 10'h3ff;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("over-range input not full scale");
endmodule

// >>> testbench/adcc_analog_model.sv
/*
 analog side of the converter: sixteen input levels, sample/hold and comparator.
 assumes the block's mux select, sample_hold, dac_code and power ports.
*/
`timescale 1ns/100ps

module adcc_analog_model (
  input wire logic aclk,
  input wire logic [15:0][10:0] levels,
  input wire logic [3:0] input_select,
  input wire logic sample_hold,
  input wire logic converter_power,
  input wire logic [9:0] dac_code,
  output logic cmp_in
);
  logic [10:0] held_r = 11'h000;
  logic junk_r = 1'b0;

  // held level follows the selected pin only while sampling
  always @(posedge aclk) begin
    junk_r <= !junk_r;
    if (sample_hold) begin
      held_r <= levels[input_select];
    end
  end

  // 11-bit level: over-range saturates the code, no overflow bit
  // powered down the comparator output is meaningless, so it toggles
  always_comb begin
    cmp_in = converter_power ? (held_r >= {1'b0, dac_code}) : junk_r;
  end
endmodule

// >>> testbench/adc_control_and_result_regs_bench.sv
/*
 self-checking bench of the converter control block over AXI4-Lite.
 assumes adcc_top, adcc_analog_model and the offsets of adcc_cfg.svh.
*/
`timescale 1ns/100ps
`include "adcc_cfg.svh"

module adc_control_and_result_regs_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, input_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic wait_mode, halt_mode, cmp_in, input_valid, converter_power, sample_hold, irq;
  logic [9:0] dac_code;
  logic [15:0][10:0] levels;
  int fail_count = 0;
  int num_checks = 0;

  adcc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .wait_mode, .halt_mode, .cmp_in, .input_select,
    .input_valid, .converter_power, .sample_hold, .dac_code, .irq);

  adcc_analog_model model_u (.aclk, .levels, .input_select, .sample_hold,
    .converter_power, .dac_code, .cmp_in);

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  // master holds bready until the answer; no cycle count assumed
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 1000);
    r = s_axi_bresp;
    if (n >= 1000) fail_count++;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 1000);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 1000) fail_count++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_val({30'h0, r}, {30'h0, `ADCC_RESP_OKAY});
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
  endtask

  task automatic wait_done(output logic [31:0] c);
    int n;
    n = 0;
    do begin
      rd(`ADCC_ADDR_CSR, c);
      n++;
    end while (c[7] !== 1'b1 && n < 400);
    if (n >= 400) fail_count++;
  endtask

  // low byte first, high last: the pair is not latched
  task automatic t_result(input logic [9:0] lvl);
    logic [31:0] d;
    rd(`ADCC_ADDR_RES_LOW, d);
    chk_val(d, {30'h0, lvl[1:0]});
    rd(`ADCC_ADDR_RES_HIGH, d);
    chk_val(d, {24'h0, lvl[9:2]});
  endtask

  task automatic wait_conv();
    int n;
    n = 0;
    while (sample_hold !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    while (sample_hold !== 1'b0 && n < 400) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // spacing of trial codes: two conversion clocks per bit
  task automatic t_step(input int exp);
    logic [9:0] code;
    int m;
    wait_conv();
    code = dac_code;
    m = 0;
    while (dac_code === code && m < 100) begin
      @(posedge aclk);
      m++;
    end
    code = dac_code;
    m = 0;
    while (dac_code === code && m < 100) begin
      @(posedge aclk);
      m++;
    end
    chk_val(m, exp);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(`ADCC_ADDR_CSR, d);
    chk_val(d, 32'h0);
    rd(`ADCC_ADDR_RES_HIGH, d);
    chk_val(d, 32'h0);
    rd(`ADCC_ADDR_RES_LOW, d);
    chk_val(d, 32'h0);
    chk_bit(converter_power, 1'b0);
    chk_bit(irq, 1'b0);
    axi_read(12'h000, d, r);
    chk_val({30'h0, r}, {30'h0, `ADCC_RESP_SLVERR});
    axi_write(`ADCC_ADDR_RES_HIGH, 8'hff, r);
    chk_val({30'h0, r}, {30'h0, `ADCC_RESP_SLVERR});
  endtask

  task automatic t_convert(input logic [3:0] ch, input logic sp, input logic [9:0] lvl, input int stp);
    logic [31:0] d;
    wr(`ADCC_ADDR_CSR, {1'b0, sp, 1'b1, 1'b0, ch});
    chk_val({28'h0, input_select}, {28'h0, ch});
    chk_bit(input_valid, 1'b1);
    chk_bit(converter_power, 1'b1);
    t_step(stp);
    wait_done(d);
    t_result(lvl);
    rd(`ADCC_ADDR_CSR, d);
    chk_val(d, {24'h0, 1'b0, sp, 1'b1, 1'b0, ch});
    wait_done(d);
    chk_val(d, {24'h0, 1'b1, sp, 1'b1, 1'b0, ch});
  endtask

  task automatic t_abort();
    logic [31:0] d;
    int n;
    wait_conv();
    repeat (20) @(posedge aclk);
    wr(`ADCC_ADDR_CSR, 8'h29);
    n = 0;
    while (sample_hold !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk_bit(n < 12, 1'b1);
    rd(`ADCC_ADDR_CSR, d);
    chk_bit(d[7], 1'b0);
    chk_val({28'h0, input_select}, 32'h9);
    wait_done(d);
    t_result(10'h0a5);
  endtask

  task automatic t_modes();
    logic [31:0] d;
    wr(`ADCC_ADDR_CSR, 8'h23);
    wait_mode <= 1'b1;
    wait_done(d);
    chk_bit(converter_power, 1'b1);
    rd(`ADCC_ADDR_RES_HIGH, d);
    wait_mode <= 1'b0;
    halt_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_bit(converter_power, 1'b0);
    repeat (50) @(posedge aclk);
    halt_mode <= 1'b0;
    rd(`ADCC_ADDR_AUX_STATUS, d);
    chk_bit(d[0], 1'b1);
    // software side waits out the settling time before trusting results
    repeat (110) @(posedge aclk);
    rd(`ADCC_ADDR_AUX_STATUS, d);
    chk_bit(d[0], 1'b0);
    wait_done(d);
    t_result(10'h2b6);
  endtask

  task automatic t_off();
    logic [31:0] d;
    logic seen;
    seen = 1'b0;
    wr(`ADCC_ADDR_CSR, 8'h03);
    chk_bit(converter_power, 1'b0);
    repeat (150) begin
      @(posedge aclk);
      seen = seen | sample_hold;
    end
    chk_bit(seen, 1'b0);
    rd(`ADCC_ADDR_CSR, d);
    chk_val(d, 32'h03);
    // low lane not strobed: the write must leave csr untouched
    s_axi_wstrb <= 4'he;
    wr(`ADCC_ADDR_CSR, 8'h25);
    s_axi_wstrb <= 4'hf;
    rd(`ADCC_ADDR_CSR, d);
    chk_val(d, 32'h03);
    rd(`ADCC_ADDR_IRQ_STATUS, d);
    chk_bit(d[0], 1'b1);
    chk_bit(irq, 1'b0);
    wr(`ADCC_ADDR_IRQ_MASK, 8'h01);
    chk_bit(irq, 1'b1);
    wr(`ADCC_ADDR_IRQ_STATUS, 8'h03);
    chk_bit(irq, 1'b0);
    rd(`ADCC_ADDR_IRQ_STATUS, d);
    chk_val(d, 32'h0);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // whole run needs well under two thousand cycles
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    wait_mode = 1'b0;
    halt_mode = 1'b0;
    levels = '0;
    levels[3] = 11'h2b6;
    levels[5] = 11'h7ff;
    levels[9] = 11'h0a5;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_convert(4'h3, 1'b1, 10'h2b6, 4);
    t_convert(4'h5, 1'b0, 10'h3ff, 8);
    t_abort();
    t_modes();
    t_off();
    finish_test();
  end
endmodule
